// ### src/sar_pkg.sv
package sar_pkg;
  localparam int RES_BITS = 12;
  localparam int FRAME_CLOCKS = 16;
  localparam logic [4:0] CNT_LEAD_LAST = 5'h03;
  localparam logic [4:0] CNT_RES_TOP = 5'h0c;
  localparam logic [4:0] CNT_TRACK_AFTER = 5'h0d;
  localparam logic [4:0] CNT_LAST_LAUNCH = 5'h0f;
  localparam logic [4:0] CNT_FRAME_LAST = 5'h10;
  localparam logic [7:0] RISE_CAPTURE_LAST = 8'h0f;
  localparam logic [7:0] FALL_CAPTURE_LAST = 8'h10;
  localparam logic [11:0] CODE_ONE = 12'h001;

  localparam int CORE_PERIOD_PS = 5000;
  localparam int SCLK_MAX_KHZ = 18000;
  localparam int LEAD_TIME_NS = 10;
  localparam int ACQ_TIME_NS = 200;
  localparam int QUIET_TIME_NS = 25;
  localparam int RELEASE_TIME_NS = 35;

  localparam int LEAD_CYCLES = (LEAD_TIME_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
  localparam int ACQ_CYCLES = (ACQ_TIME_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
  localparam int QUIET_CYCLES =
    ((QUIET_TIME_NS + RELEASE_TIME_NS) * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
  localparam int GAP_CYCLES = (ACQ_CYCLES > QUIET_CYCLES) ? ACQ_CYCLES : QUIET_CYCLES;
  localparam int SCLK_HALF_DEF =
    (1000000000 / SCLK_MAX_KHZ + 2 * CORE_PERIOD_PS - 1) / (2 * CORE_PERIOD_PS);

  typedef enum {
    H_IDLE,
    H_LEAD,
    H_LOW,
    H_HIGH,
    H_GAP
  } sar_host_st_type;

  // differential span -ref..+ref onto offset binary 0..4095
  function automatic logic [RES_BITS-1:0] sar_to_code(input logic [RES_BITS-1:0] diff);
    sar_to_code = {~diff[RES_BITS-1], diff[RES_BITS-2:0]};
  endfunction
endpackage

// ### src/sar_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sar_link_if;
  logic cs_n;
  logic sclk;
  logic serial_result_out_drv;
  logic serial_result_out_oe;
  logic serial_result_out;

  // released line reads low
  assign serial_result_out = serial_result_out_oe & serial_result_out_drv;

  modport dev(input cs_n, input sclk, output serial_result_out_drv, output serial_result_out_oe);
  modport host(output cs_n, output sclk, input serial_result_out);
endinterface
`default_nettype wire

// ### src/sar_sync3.sv
`timescale 1ns/100ps
`default_nettype none
module sar_sync3 (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_async,
  output logic o_sync
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic out;
  } sar_sync_type;

  sar_sync_type s_q;
  sar_sync_type s_d;

  always_comb begin
    s_d = s_q;
    s_d.s1 = i_async;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    // change taken only once second and third stage agree
    if (s_q.s2 == s_q.s3) begin
      s_d.out = s_q.s3;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_sync = s_q.out;
endmodule
`default_nettype wire

// ### src/sar_adc_device.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - select fall holds input, starts conversion, drives
// - serial clock converts; sixteen clocks complete frame
// - after thirteenth fall, track on next rise
// - sixteenth fall releases the serial output
// - early select rise aborts and releases output
// - first zero at select fall, rest on falls
// - last bit launched at fifteenth fall
// - host waits acquisition time before next frame
// - host keeps quiet gap after output release
// - host cycle budget: lead, clocks, acquisition
// - host may issue longer bursts per conversion
// - host may capture on rising edges instead
// - host frames every transfer with low select
// - differential span maps onto codes 0..4095
module sar_adc_device import sar_pkg::*; (
  sar_link_if.dev link,
  input wire logic i_nrst,
  input wire logic [RES_BITS-1:0] i_diff_in,
  output logic o_holding,
  output logic [RES_BITS-1:0] o_last_code
);
  typedef enum {
    F_LEAD,
    F_RESULT,
    F_LAST,
    F_RELEASED
  } sar_phase_type;

  typedef struct packed {
    logic [4:0] cnt;
    logic [RES_BITS-1:0] result;
    logic dout;
    logic done;
    sar_phase_type phase;
  } sar_frame_type;

  typedef struct packed {
    logic [RES_BITS-1:0] last_code;
    logic holding;
  } sar_track_type;

  sar_frame_type fr_q;
  sar_frame_type fr_d;
  sar_track_type tr_q;
  sar_track_type tr_d;
  logic retrack_q;
  logic frame_rst_n;
  logic tracking;
  logic [4:0] fall_k;
  logic [RES_BITS-1:0] res_next;
  logic [RES_BITS-1:0] held_q;
  logic driving;

  // fall count that the coming falling edge will reach
  assign fall_k = fr_q.cnt + 5'h01;

  // one trial per bit, msb first: lower bits are still zero when a bit is weighed,
  // so the trial is the running result with that bit added
  generate
    for (genvar gi = 0; gi < RES_BITS; gi++) begin : g_sar
      logic [RES_BITS-1:0] trial;
      logic decide;
      assign trial = fr_q.result | (CODE_ONE << gi);
      assign decide = (fall_k == CNT_RES_TOP - 5'(gi));
      assign res_next[gi] = decide ? (held_q >= trial) : fr_q.result[gi];
    end
  endgenerate

  // bit of the frame launched at falling edge k
  function automatic logic frame_bit(
    input logic [4:0] k,
    input logic [RES_BITS-1:0] r
  );
    logic [4:0] idx;
    idx = CNT_LAST_LAUNCH - k;
    frame_bit = 1'b0;
    if (k > CNT_LEAD_LAST && k < CNT_FRAME_LAST) begin
      frame_bit = r[idx[3:0]];
    end
  endfunction

  // frame state lives only while select is low
  assign frame_rst_n = i_nrst & ~link.cs_n;

  // launch side of the frame, stepped on every falling edge
  always_comb begin
    fr_d = fr_q;
    case (fr_q.phase)
      F_LEAD: begin
        fr_d.cnt = fall_k;
        fr_d.result = res_next;
        fr_d.dout = frame_bit(fall_k, fr_q.result);
        if (fall_k == CNT_LEAD_LAST) begin
          fr_d.phase = F_RESULT;
        end
      end
      F_RESULT: begin
        fr_d.cnt = fall_k;
        fr_d.result = res_next;
        fr_d.dout = frame_bit(fall_k, fr_q.result);
        if (fall_k == CNT_LAST_LAUNCH) begin
          fr_d.phase = F_LAST;
        end
      end
      F_LAST: begin
        // last bit is taken on this fall, so the line is let go
        fr_d.cnt = fall_k;
        fr_d.dout = 1'b0;
        fr_d.done = 1'b1;
        fr_d.phase = F_RELEASED;
      end
      F_RELEASED: begin
        // extra clocks of a longer burst change nothing until select rises
        fr_d.done = 1'b1;
      end
      default: begin
        fr_d.done = 1'b1;
        fr_d.phase = F_RELEASED;
      end
    endcase
  end

  always_ff @(negedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      fr_q <= '0;
    end else begin
      fr_q <= fr_d;
    end
  end

  // back to track on the rising edge after the thirteenth fall
  always_ff @(posedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      retrack_q <= 1'b0;
    end else if (fr_q.cnt >= CNT_TRACK_AFTER) begin
      retrack_q <= 1'b1;
    end
  end

  // select low freezes the held value until retrack
  assign tracking = link.cs_n | retrack_q;

  always_comb begin
    tr_d = tr_q;
    tr_d.holding = ~tracking;
    if (fr_q.done) begin
      tr_d.last_code = fr_q.result;
    end
  end

  // input frozen at the select fall itself, so a host that parks the
  // clock between frames still converts what it applied before the fall
  always_ff @(negedge link.cs_n or negedge i_nrst) begin
    if (!i_nrst) begin
      held_q <= '0;
    end else begin
      held_q <= sar_to_code(i_diff_in);
    end
  end

  always_ff @(posedge link.sclk or negedge i_nrst) begin
    if (!i_nrst) begin
      tr_q <= '0;
    end else begin
      tr_q <= tr_d;
    end
  end

  // output driven from select fall until release; first bit is zero
  assign link.serial_result_out_drv = fr_q.dout;
  // combinational, so an early select rise frees the line at once
  assign driving = ~link.cs_n & ~fr_q.done & i_nrst;
  assign link.serial_result_out_oe = driving;

  assign o_holding = tr_q.holding;
  assign o_last_code = tr_q.last_code;
endmodule
`default_nettype wire

// ### src/sar_adc_host.sv
`timescale 1ns/100ps
`default_nettype none
module sar_adc_host import sar_pkg::*; #(
  parameter int SCLK_HALF = SCLK_HALF_DEF,
  parameter int BURST = FRAME_CLOCKS
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  sar_link_if.host link,
  input wire logic i_start,
  input wire logic i_rise_capture,
  output logic [RES_BITS-1:0] o_result,
  output logic o_valid,
  output logic o_busy
);
  typedef struct packed {
    sar_host_st_type st;
    logic [7:0] cnt;
    logic [7:0] edges;
    logic [FRAME_CLOCKS-1:0] shift;
    logic [RES_BITS-1:0] result;
    logic valid;
    logic busy;
    logic cs_n;
    logic sclk;
  } sar_host_type;

  localparam logic [7:0] LEAD_CNT = 8'(LEAD_CYCLES - 1);
  localparam logic [7:0] HALF_CNT = 8'(SCLK_HALF - 1);
  localparam logic [7:0] GAP_CNT = 8'(GAP_CYCLES - 1);
  localparam logic [7:0] BURST_CNT = 8'(BURST);

  sar_host_type h_q;
  sar_host_type h_d;
  logic serial_result_out_s;

  sar_sync3 u_sync (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_async(link.serial_result_out),
    .o_sync(serial_result_out_s)
  );

  always_comb begin
    h_d = h_q;
    h_d.valid = 1'b0;
    case (h_q.st)
      H_IDLE: begin
        h_d.busy = 1'b0;
        if (i_start) begin
          h_d.busy = 1'b1;
          h_d.cs_n = 1'b0;
          h_d.cnt = LEAD_CNT;
          h_d.edges = 8'h00;
          h_d.shift = '0;
          h_d.st = H_LEAD;
        end
      end
      H_LEAD, H_HIGH: begin
        if (h_q.cnt != 8'h00) begin
          h_d.cnt = h_q.cnt - 8'h01;
        end else if (h_q.st == H_HIGH && h_q.edges == BURST_CNT) begin
          h_d.cs_n = 1'b1;
          h_d.result = h_q.shift[RES_BITS-1:0];
          h_d.valid = 1'b1;
          h_d.cnt = GAP_CNT;
          h_d.st = H_GAP;
        end else begin
          h_d.sclk = 1'b0;
          h_d.edges = h_q.edges + 8'h01;
          h_d.cnt = HALF_CNT;
          h_d.st = H_LOW;
          // bit launched on the previous fall, taken at this fall
          if (!i_rise_capture && h_d.edges <= FALL_CAPTURE_LAST) begin
            h_d.shift = {h_q.shift[FRAME_CLOCKS-2:0], serial_result_out_s};
          end
        end
      end
      H_LOW: begin
        if (h_q.cnt != 8'h00) begin
          h_d.cnt = h_q.cnt - 8'h01;
        end else begin
          h_d.sclk = 1'b1;
          h_d.cnt = HALF_CNT;
          h_d.st = H_HIGH;
          if (i_rise_capture && h_q.edges <= RISE_CAPTURE_LAST) begin
            h_d.shift = {h_q.shift[FRAME_CLOCKS-2:0], serial_result_out_s};
          end
        end
      end
      H_GAP: begin
        // acquisition and quiet time before the next select fall
        if (h_q.cnt != 8'h00) begin
          h_d.cnt = h_q.cnt - 8'h01;
        end else begin
          h_d.busy = 1'b0;
          h_d.st = H_IDLE;
        end
      end
      default: begin
        h_d.st = H_IDLE;
        h_d.cs_n = 1'b1;
        h_d.sclk = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      h_q <= '{st: H_IDLE, cnt: 8'h00, edges: 8'h00, shift: '0, result: '0,
               valid: 1'b0, busy: 1'b0, cs_n: 1'b1, sclk: 1'b1};
    end else begin
      h_q <= h_d;
    end
  end

  assign link.cs_n = h_q.cs_n;
  assign link.sclk = h_q.sclk;
  assign o_result = h_q.result;
  assign o_valid = h_q.valid;
  assign o_busy = h_q.busy;
endmodule
`default_nettype wire

// ### testbench/sar_link_properties.sv
`timescale 1ns/100ps
`default_nettype none
module sar_link_properties import sar_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_result_out_drv,
  input wire logic serial_result_out_oe,
  input wire logic serial_result_out
);
  logic [4:0] nfall_q;
  logic [7:0] gap_q;

  // falls seen in the frame, saturating at the frame length
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      nfall_q <= 5'h00;
      gap_q <= 8'hff;
    end else begin
      if (cs_n) nfall_q <= 5'h00;
      else if ($fell(sclk) && nfall_q != CNT_FRAME_LAST) nfall_q <= nfall_q + 5'h01;
      if (!cs_n) gap_q <= 8'h00;
      else if (gap_q != 8'hff) gap_q <= gap_q + 8'h01;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  property p_drive_at_select;
    $fell(cs_n) |-> serial_result_out_oe && !serial_result_out;
  endproperty
  a_drive_at_select: assert property (p_drive_at_select)
    else $error("select fall without zero drive");
  property p_abort;
    $rose(cs_n) |-> !serial_result_out_oe;
  endproperty
  a_abort: assert property (p_abort)
    else $error("line driven after select rise");
  property p_release;
    nfall_q == CNT_FRAME_LAST |-> !serial_result_out_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("line driven after last fall");
  property p_driven;
    !cs_n && nfall_q < CNT_FRAME_LAST && !$fell(sclk) |-> serial_result_out_oe;
  endproperty
  a_driven: assert property (p_driven)
    else $error("line released mid frame");
  property p_lead_zero;
    !cs_n && nfall_q <= CNT_LEAD_LAST && !$fell(sclk) |-> !serial_result_out;
  endproperty
  a_lead_zero: assert property (p_lead_zero)
    else $error("leading bit not zero");
  property p_launch_on_fall;
    !cs_n && !$fell(cs_n) && $changed(serial_result_out) |-> $fell(sclk);
  endproperty
  a_launch_on_fall: assert property (p_launch_on_fall)
    else $error("data changed off a falling edge");
  property p_frame_len;
    $rose(cs_n) |-> nfall_q == CNT_FRAME_LAST;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame ended short");
  property p_idle_high;
    cs_n |-> sclk;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("clock low outside frame");
  property p_gap;
    $fell(cs_n) |-> gap_q >= GAP_CYCLES;
  endproperty
  a_gap: assert property (p_gap)
    else $error("gap between frames too short");

  c_frame: cover property ($rose(cs_n) && nfall_q == CNT_FRAME_LAST);
  c_first: cover property ($fell(cs_n) && gap_q == 8'hff);
  c_one_bit: cover property (serial_result_out_oe && serial_result_out);
endmodule
`default_nettype wire

// ### testbench/sar_adc_serial_readout_test.sv
`timescale 1ns/100ps
`default_nettype none
module sar_adc_serial_readout_test import sar_pkg::*;;
  logic i_core_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_start = 1'b0;
  logic i_rise_capture = 1'b0;
  logic [RES_BITS-1:0] i_diff_in = 12'h000;
  logic [RES_BITS-1:0] o_result, o_last_code, last2;
  logic o_valid, o_busy, o_holding, hold2, rel;
  logic [15:0] wv;
  logic [11:0] vals [6] = '{12'h800, 12'h7ff, 12'h000, 12'hfff, 12'h555, 12'haaa};
  int error_cnt = 0;
  int comparisons = 0;
  int nr;

  sar_link_if link();
  sar_link_if link2();
  sar_adc_host #(.BURST(18)) sar_adc_host_inst(.i_core_clk(i_core_clk), .i_nrst(i_nrst),
    .link(link), .i_start(i_start), .i_rise_capture(i_rise_capture), .o_result(o_result),
    .o_valid(o_valid), .o_busy(o_busy));
  sar_adc_device sar_adc_device_inst(.link(link), .i_nrst(i_nrst), .i_diff_in(i_diff_in),
    .o_holding(o_holding), .o_last_code(o_last_code));
  sar_adc_device sar_adc_device_inst2(.link(link2), .i_nrst(i_nrst), .i_diff_in(i_diff_in),
    .o_holding(hold2), .o_last_code(last2));
  sar_link_properties sar_link_properties_inst(.i_core_clk(i_core_clk), .i_nrst(i_nrst),
    .cs_n(link.cs_n), .sclk(link.sclk), .serial_result_out_drv(link.serial_result_out_drv),
    .serial_result_out_oe(link.serial_result_out_oe), .serial_result_out(link.serial_result_out));

  always #2.5 i_core_clk = ~i_core_clk;

  // wire view: bit 15 at select fall, bit 15-k at rise k
  always @(negedge link.cs_n) begin
    #1;
    wv = {link.serial_result_out, 15'h0};
    rel = 1'b0;
    nr = 0;
  end
  always @(posedge link.sclk) begin
    if (link.cs_n === 1'b0) begin
      nr++;
      if (nr < 16) wv[15 - nr] = link.serial_result_out;
      else rel = rel | link.serial_result_out;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // converts the input applied with the start request
  task automatic frame(input logic [11:0] v, input logic rc);
    int n;
    logic [11:0] e;
    e = {~v[11], v[10:0]};
    @(posedge i_core_clk) #1;
    i_diff_in = v;
    i_rise_capture = rc;
    i_start = 1'b1;
    @(posedge i_core_clk) #1;
    i_start = 1'b0;
    repeat (30) @(posedge i_core_clk);
    chk({15'h0, o_holding}, 16'h0001);
    n = 0;
    while (o_valid !== 1'b1 && n < 400) begin
      @(posedge i_core_clk) #1;
      n++;
    end
    chk({15'h0, o_valid}, 16'h0001);
    chk({4'h0, o_result}, {4'h0, e});
    chk({4'h0, o_last_code}, {4'h0, e});
    chk(wv, {4'h0, e});
    chk({15'h0, rel}, 16'h0000);
    chk({15'h0, o_holding}, 16'h0000);
    n = 0;
    while (o_busy !== 1'b0 && n < 100) begin
      @(posedge i_core_clk) #1;
      n++;
    end
    chk({15'h0, o_busy}, 16'h0000);
    $display("frame done in=%h rise=%0d", v, rc);
  endtask

  // testbench raises select after five clocks it drives on the second link
  task automatic abort_frame;
    @(posedge i_core_clk) #1;
    link2.cs_n = 1'b0;
    repeat (5) begin
      #80 link2.sclk = 1'b0;
      #80 link2.sclk = 1'b1;
    end
    chk({15'h0, link2.serial_result_out_oe}, 16'h0001);
    link2.cs_n = 1'b1;
    #1;
    chk({15'h0, link2.serial_result_out_oe}, 16'h0000);
    chk({4'h0, last2}, 16'h0000);
    $display("abort done");
  endtask

  task tally_and_finish;
    $display("comparisons=%0d errors=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #50000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    link2.cs_n = 1'b1;
    link2.sclk = 1'b1;
    repeat (4) @(posedge i_core_clk);
    #1;
    i_nrst = 1'b1;
    for (int i = 0; i < 6; i++) frame(vals[i], i[0]);
    abort_frame();
    tally_and_finish();
  end
endmodule
`default_nettype wire
